// *** ctio_consts.vh ***
// Constants for the clock and trigger I/O block
`ifndef CTIO_CONSTS_VH
`define CTIO_CONSTS_VH
// Trigger edge selection
`define CTIO_EDGE_RISE 2'h0
`define CTIO_EDGE_FALL 2'h1
`define CTIO_EDGE_BOTH 2'h2
// Sync output modes
`define CTIO_MODE_OFF 3'h0
`define CTIO_MODE_VIDEO 3'h1
`define CTIO_MODE_BUS 3'h2
`define CTIO_MODE_COOLER 3'h3
`define CTIO_MODE_FIXED 3'h4
`define CTIO_MODE_SAMPLE 3'h5
// Expansion source selection
`define CTIO_SRC_FAST 1'h0
`define CTIO_SRC_SAMPLE 1'h1
// Master board number
`define CTIO_MASTER_ID 4'h0
// Divider width
`define CTIO_DIV_W 16
`define CTIO_DIV_ONE 16'h0001
`define CTIO_DIV_ZERO 16'h0000
// Start alignment states
`define CTIO_ST_IDLE 2'h0
`define CTIO_ST_WAIT 2'h1
`define CTIO_ST_GO 2'h2
// Synchroniser stage count
`define CTIO_SYNC_STAGES 2
`endif

// *** ctio_top.v ***
// Clock and trigger input/output logic of the acquisition board
`timescale 1ns/1ns
`include "ctio_consts.vh"

// Notes on behaviour
// - Valid edge on trigger pin, while it is an input, starts acquisition.
// - Edge select defaults rising; falling or both edges selectable.
// - Trigger pin as output drives a pulse when acquisition starts.
// - Trigger pin and each sync pin have their own direction control.
// - Each sync output has its own mode selection.
// - Video mode outputs camera frame clock; off when no camera selected.
// - Bus mode outputs bus sync signal; off when no device selected.
// - Cooler mode switches fan off while data is being stored.
// - Fixed mode divides the 12.8 MHz sample oscillator, synchronous to it.
// - Fixed mode clock runs only during acquisition unless continuous.
// - Continuous selection keeps the clock running after acquisition stops.
// - Continuous on third sync output aligns start to its rising edge.
// - Fixed clock phase-aligned to sample clock only on master board.
// - Sample mode reproduces the acquisition sample clock.
// - Continuous sample mode allowed only on board 0, rejected elsewhere.
// - Master defaults: first video, second bus sync, third off.
// - Slave boards default all sync outputs off.
// - Two expansion channels, each choosing fast clock or sample clock.
// - Each channel divides its source with programmable high and low counts.
// - Expansion channels active only in acquisition mode, else held low.
// - Master ignores external sync input and asserts local master indicator.
// - Remote master indicator set on a non-master while valid external sync is present.
module ctio_top #(
  parameter DIV_W = `CTIO_DIV_W
) (
  input wire mclk,
  input wire rst,
  input wire [3:0] board_id,
  input wire mode_apply,
  input wire [1:0] trig_edge_sel,
  input wire trig_dir_out,
  input wire acq_start_pin_in,
  output reg acq_start_pin_out,
  output reg acq_start_pin_oe,
  input wire sw_start,
  input wire acq_stop,
  output reg acq_running,
  output reg acq_start_pulse,
  input wire [8:0] sync_mode_cfg,
  input wire [2:0] sync_cont_cfg,
  input wire [2:0] sync_dir_out,
  input wire [2:0] sync_in,
  output reg [2:0] sync_clock_outputs,
  output reg [2:0] sync_oe,
  output reg cont_rejected,
  input wire camera_selected,
  input wire frame_clk,
  input wire bus_dev_selected,
  input wire bus_sync,
  input wire storing,
  input wire osc_tick,
  input wire [DIV_W-1:0] fixed_half,
  input wire sample_clk,
  input wire fast_clk,
  input wire exp_acq_mode,
  input wire [1:0] exp_src_sel,
  input wire [2*DIV_W-1:0] exp_high,
  input wire [2*DIV_W-1:0] exp_low,
  output reg [1:0] exp_out,
  input wire is_master,
  input wire ext_sync_in,
  input wire ext_sync_valid,
  output reg local_master_indicator,
  output reg remote_master_indicator,
  output reg ext_sync_used
);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  // Everything arriving from pins or other clocks passes two stages, except sync_in[2], which is not sampled
  reg [10:0] sync_a;
  reg [10:0] sync_b;
  wire [10:0] raw_in = {ext_sync_valid, ext_sync_in, fast_clk, sample_clk, osc_tick,
    storing, bus_sync, frame_clk, sync_in[0], sync_in[1], acq_start_pin_in};
  always @(posedge mclk)
  begin
    if (rst)
    begin
      sync_a <= 11'h000;
      sync_b <= 11'h000;
    end
    else
    begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end
  wire trig_s = sync_b[0];
  wire frame_s = sync_b[3];
  wire bsync_s = sync_b[4];
  wire store_s = sync_b[5];
  wire osc_s = sync_b[6];
  wire samp_s = sync_b[7];
  wire fast_s = sync_b[8];
  wire xsync_s = sync_b[9];
  wire xvalid_s = sync_b[10];

  // ==========================================================
  // Trigger edge detection
  // ==========================================================
  reg trig_d;
  reg osc_d;
  reg samp_d;
  reg fast_d;
  reg init_pending;
  // Delayed copies for edge detection; init_pending marks the first cycle after release
  always @(posedge mclk)
  begin
    if (rst)
    begin
      trig_d <= 1'b0;
      osc_d <= 1'b0;
      samp_d <= 1'b0;
      fast_d <= 1'b0;
      init_pending <= 1'b1;
    end
    else
    begin
      trig_d <= trig_s;
      osc_d <= osc_s;
      samp_d <= samp_s;
      fast_d <= fast_s;
      init_pending <= 1'b0;
    end
  end
  wire rise = trig_s & ~trig_d;
  wire fall = ~trig_s & trig_d;
  reg trig_hit;
  // Edge choice; unknown codes fall back to rising
  always @*
  begin
    case (trig_edge_sel)
      `CTIO_EDGE_FALL: trig_hit = fall;
      `CTIO_EDGE_BOTH: trig_hit = rise | fall;
      default: trig_hit = rise;
    endcase
  end
  // Only counts while the pin is an input
  wire start_req = (trig_hit & ~trig_dir_out) | sw_start;
  wire osc_rise = osc_s & ~osc_d;

  // ==========================================================
  // Mode registers and defaults
  // ==========================================================
  function [2:0] ctio_mode;
    input [8:0] cfg;
    input [1:0] idx;
    begin
      ctio_mode = cfg[idx*3 +: 3];
    end
  endfunction
  wire master_board = (board_id == `CTIO_MASTER_ID);
  reg [8:0] mode_r;
  reg [2:0] cont_r;
  integer k;
  // Defaults depend on board role; apply loads a new set
  always @(posedge mclk)
  begin
    if (rst)
    begin
      mode_r <= {9{1'b0}};
      cont_r <= 3'h0;
      cont_rejected <= 1'b0;
    end
    else if (mode_apply)
    begin
      cont_rejected <= 1'b0;
      for (k = 0; k < 3; k = k + 1)
      begin
        mode_r[k*3 +: 3] <= ctio_mode(sync_mode_cfg, k[1:0]);
        // Sample continuous on a slave board is refused
        if (sync_cont_cfg[k] && !master_board && ctio_mode(sync_mode_cfg, k[1:0]) == `CTIO_MODE_SAMPLE)
        begin
          cont_r[k] <= 1'b0;
          cont_rejected <= 1'b1;
        end
        else
          cont_r[k] <= sync_cont_cfg[k];
      end
    end
    else if (!rst && mode_r == {9{1'b0}} && !acq_running && cont_r == 3'h0 && init_pending)
    begin
      // One-time role defaults after reset release
      if (master_board)
        mode_r <= {`CTIO_MODE_OFF, `CTIO_MODE_BUS, `CTIO_MODE_VIDEO};
      else
        mode_r <= {`CTIO_MODE_OFF, `CTIO_MODE_OFF, `CTIO_MODE_OFF};
    end
  end
  // ==========================================================
  // Fixed-frequency divider on the sample oscillator
  // ==========================================================
  reg [DIV_W-1:0] fix_cnt;
  reg fix_clk;
  wire any_cont_fixed = |cont_r;
  // Master restarts the divider at start, unless any sync output is continuous, so phase follows the sample clock
  always @(posedge mclk)
  begin
    if (rst)
    begin
      fix_cnt <= {DIV_W{1'b0}};
      fix_clk <= 1'b0;
    end
    else if (start_req && master_board && !acq_running && !any_cont_fixed)
    begin
      fix_cnt <= {DIV_W{1'b0}};
      fix_clk <= 1'b0;
    end
    else if (osc_rise)
    begin
      if (fix_cnt + `CTIO_DIV_ONE >= fixed_half)
      begin
        fix_cnt <= {DIV_W{1'b0}};
        fix_clk <= ~fix_clk;
      end
      else
        fix_cnt <= fix_cnt + `CTIO_DIV_ONE;
    end
  end
  wire fix_rise_next = osc_rise && !fix_clk && (fix_cnt + `CTIO_DIV_ONE >= fixed_half);

  // ==========================================================
  // Acquisition start sequencing
  // ==========================================================
  reg [1:0] st;
  wire align3 = cont_r[2] && (mode_r[8:6] == `CTIO_MODE_FIXED);
  always @(posedge mclk)
  begin
    if (rst)
    begin
      st <= `CTIO_ST_IDLE;
      acq_running <= 1'b0;
      acq_start_pulse <= 1'b0;
    end
    else
    begin
      acq_start_pulse <= 1'b0;
      case (st)
        `CTIO_ST_IDLE:
          if (start_req)
            st <= align3 ? `CTIO_ST_WAIT : `CTIO_ST_GO;
        `CTIO_ST_WAIT:
          if (fix_rise_next)
            st <= `CTIO_ST_GO;
        `CTIO_ST_GO:
        begin
          acq_running <= 1'b1;
          acq_start_pulse <= ~acq_running;
          if (acq_stop)
          begin
            acq_running <= 1'b0;
            st <= `CTIO_ST_IDLE;
          end
        end
        default: st <= `CTIO_ST_IDLE;
      endcase
    end
  end

  // Trigger pin drives the start indication when set as output
  always @(posedge mclk)
  begin
    if (rst)
    begin
      acq_start_pin_out <= 1'b0;
      acq_start_pin_oe <= 1'b0;
    end
    else
    begin
      acq_start_pin_oe <= trig_dir_out;
      acq_start_pin_out <= trig_dir_out & (st == `CTIO_ST_GO) & ~acq_running;
    end
  end

  // ==========================================================
  // Sync clock outputs
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_sync
      reg sel;
      // Per-output mode mux
      always @*
      begin
        case (mode_r[g*3 +: 3])
          `CTIO_MODE_VIDEO: sel = camera_selected & frame_s;
          `CTIO_MODE_BUS: sel = bus_dev_selected & bsync_s;
          `CTIO_MODE_COOLER: sel = ~store_s;
          `CTIO_MODE_FIXED: sel = fix_clk & (acq_running | cont_r[g]);
          `CTIO_MODE_SAMPLE: sel = samp_s & (acq_running | cont_r[g]);
          default: sel = 1'b0;
        endcase
      end
      always @(posedge mclk)
      begin
        if (rst)
        begin
          sync_clock_outputs[g] <= 1'b0;
          sync_oe[g] <= 1'b0;
        end
        else
        begin
          sync_oe[g] <= sync_dir_out[g];
          sync_clock_outputs[g] <= sync_dir_out[g] & sel;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Expansion output channels
  // ==========================================================
  // Source is sampled on mclk, so the fast clock is only usable below mclk/2
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_exp
      reg [DIV_W-1:0] cnt;
      wire tick = (exp_src_sel[g] == `CTIO_SRC_SAMPLE) ? (samp_s & ~samp_d) : (fast_s & ~fast_d);
      wire [DIV_W-1:0] lim = exp_out[g] ? exp_high[g*DIV_W +: DIV_W] : exp_low[g*DIV_W +: DIV_W];
      always @(posedge mclk)
      begin
        if (rst || !exp_acq_mode)
        begin
          cnt <= {DIV_W{1'b0}};
          exp_out[g] <= 1'b0;
        end
        else if (tick)
        begin
          if (cnt + `CTIO_DIV_ONE >= lim)
          begin
            cnt <= {DIV_W{1'b0}};
            exp_out[g] <= ~exp_out[g];
          end
          else
            cnt <= cnt + `CTIO_DIV_ONE;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Master and external sync gating
  // ==========================================================
  always @(posedge mclk)
  begin
    if (rst)
    begin
      local_master_indicator <= 1'b0;
      remote_master_indicator <= 1'b0;
      ext_sync_used <= 1'b0;
    end
    else
    begin
      local_master_indicator <= is_master;
      ext_sync_used <= ~is_master & xsync_s;
      remote_master_indicator <= ~is_master & xvalid_s;
    end
  end

endmodule // ctio_top

// *** ctio_asserts.sv ***
// Property checker for the clock and trigger I/O block
`timescale 1ns/1ns
module ctio_asserts (
  input wire mclk,
  input wire rst,
  input wire [3:0] board_id,
  input wire mode_apply,
  input wire trig_dir_out,
  input wire sw_start,
  input wire [8:0] sync_mode_cfg,
  input wire [2:0] sync_cont_cfg,
  input wire [2:0] sync_clock_outputs,
  input wire acq_start_pin_out,
  input wire acq_start_pin_oe,
  input wire acq_running,
  input wire acq_start_pulse,
  input wire cont_rejected,
  input wire exp_acq_mode,
  input wire [1:0] exp_out,
  input wire is_master,
  input wire ext_sync_valid,
  input wire local_master_indicator,
  input wire remote_master_indicator
);
  reg [2:0] mst_age;
  reg [2:0] val_age;
  // Requests that the block must refuse or align
  wire ask_rej = (sync_mode_cfg[2:0] == 3'h5 && sync_cont_cfg[0]) || (sync_mode_cfg[5:3] == 3'h5 && sync_cont_cfg[1])
    || (sync_mode_cfg[8:6] == 3'h5 && sync_cont_cfg[2]);
  wire aligned = sync_mode_cfg[8:6] == 3'h4 && sync_cont_cfg[2];
  // Level ages; the synchronisers need a few cycles before indicators follow
  always @(posedge mclk)
  begin
    if (rst || !is_master)
      mst_age <= 3'h0;
    else if (mst_age != 3'h7)
      mst_age <= mst_age + 3'h1;
    if (rst || is_master || !ext_sync_valid)
      val_age <= 3'h0;
    else if (val_age != 3'h7)
      val_age <= val_age + 3'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ============================================================
  // Start and trigger pin
  AST_PULSE_ONE: assert property (acq_start_pulse |=> !acq_start_pulse)
    else $error("start pulse too long");
  AST_PULSE_RUN: assert property (acq_start_pulse |-> acq_running && !$past(acq_running))
    else $error("start pulse without fresh run");
  AST_SW_LAT: assert property (sw_start && !acq_running && !acq_start_pulse && !aligned |-> ##2 acq_start_pulse)
    else $error("software start late");
  AST_PIN_MARK: assert property (acq_start_pin_out |-> acq_start_pulse && acq_start_pin_oe)
    else $error("pin pulse out of place");
  AST_PIN_DIR: assert property (trig_dir_out == $past(trig_dir_out) && !$past(rst) |-> acq_start_pin_oe == trig_dir_out)
    else $error("pin direction wrong");
  // ============================================================
  // Modes, expansion and sync bus
  AST_REJECT: assert property (mode_apply && ask_rej && board_id != 4'h0 |-> ##[1:3] cont_rejected)
    else $error("continuous sample clock not refused");
  AST_SLAVE_OFF: assert property ($fell(rst) && board_id != 4'h0 |-> ##1 (sync_clock_outputs == 3'h0) [*8])
    else $error("slave output not off");
  AST_EXP_IDLE: assert property (!exp_acq_mode && !$past(exp_acq_mode) && !$past(rst) |-> exp_out == 2'h0)
    else $error("expansion active outside acquisition");
  AST_MASTER: assert property (mst_age == 3'h7 |-> local_master_indicator && !remote_master_indicator)
    else $error("master indication wrong");
  AST_REMOTE: assert property (val_age == 3'h7 |-> remote_master_indicator)
    else $error("remote master not shown");
  cover property (acq_start_pulse && acq_start_pin_out);
  cover property ($rose(exp_out[1]));
  cover property ($rose(cont_rejected));
endmodule // ctio_asserts
bind ctio_top ctio_asserts chk (.mclk(mclk), .rst(rst), .board_id(board_id), .mode_apply(mode_apply),
  .trig_dir_out(trig_dir_out), .sw_start(sw_start), .sync_mode_cfg(sync_mode_cfg), .sync_cont_cfg(sync_cont_cfg),
  .sync_clock_outputs(sync_clock_outputs), .acq_start_pin_out(acq_start_pin_out), .acq_start_pin_oe(acq_start_pin_oe),
  .acq_running(acq_running), .acq_start_pulse(acq_start_pulse), .cont_rejected(cont_rejected),
  .exp_acq_mode(exp_acq_mode), .exp_out(exp_out), .is_master(is_master), .ext_sync_valid(ext_sync_valid),
  .local_master_indicator(local_master_indicator), .remote_master_indicator(remote_master_indicator));

// *** ctio_far_end.sv ***
// Behavioural model of the equipment around the clock and trigger block
`timescale 1ns/1ns
module ctio_far_end (
  output reg frame_clk,
  output reg bus_sync,
  output reg osc_tick,
  output reg sample_clk,
  output reg fast_clk,
  output reg ext_sync_in
);
  // ============================================================
  // Free-running sources, none phase related to the bench clock
  initial
  begin
    {frame_clk, bus_sync, osc_tick, sample_clk, fast_clk, ext_sync_in} = 6'h00;
  end
  always #153 frame_clk = !frame_clk;
  always #101 bus_sync = !bus_sync;
  // 12.8 MHz oscillator, half period rounded to whole nanoseconds
  always #39 osc_tick = !osc_tick;
  always #57 sample_clk = !sample_clk;
  // Fast source scaled down: the block samples it with the 50 MHz clock
  always #83 fast_clk = !fast_clk;
  always #251 ext_sync_in = !ext_sync_in;
endmodule // ctio_far_end

// *** clock_trigger_io_test.sv ***
// Self-checking testbench of the clock and trigger I/O block
`timescale 1ns/1ns
module clock_trigger_io_test;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] board_id = 4'h0;
  reg mode_apply = 1'b0;
  reg [1:0] trig_edge_sel = 2'h0;
  reg trig_dir_out = 1'b0;
  reg pin = 1'b0;
  reg sw_start = 1'b0;
  reg acq_stop = 1'b0;
  reg [8:0] mode_cfg = 9'h000;
  reg [2:0] cont_cfg = 3'h0;
  reg [2:0] dir_cfg = 3'h7;
  reg camera_selected = 1'b1;
  reg bus_dev_selected = 1'b1;
  reg storing = 1'b0;
  reg exp_acq_mode = 1'b0;
  reg [1:0] exp_src_sel = 2'h0;
  reg is_master = 1'b0;
  reg ext_sync_valid = 1'b0;
  reg a;
  wire frame_clk, bus_sync, osc_tick, sample_clk, fast_clk, ext_sync_in;
  wire pin_out, pin_oe, acq_running, pulse, cont_rejected, lmi, rmi, ext_sync_used;
  wire [2:0] sync_clock_outputs;
  wire [2:0] sync_oe;
  wire [1:0] exp_out;
  wire [7:0] watch = {ext_sync_used, pin_out, pulse, exp_out, sync_clock_outputs};
  integer bad_count = 0;
  integer compares = 0;
  integer cycles = 0;
  integer tg, i, j, k;
  ctio_far_end far (.frame_clk(frame_clk), .bus_sync(bus_sync), .osc_tick(osc_tick), .sample_clk(sample_clk),
    .fast_clk(fast_clk), .ext_sync_in(ext_sync_in));
  ctio_top dut (.mclk(mclk), .rst(rst), .board_id(board_id), .mode_apply(mode_apply), .trig_edge_sel(trig_edge_sel),
    .trig_dir_out(trig_dir_out), .acq_start_pin_in(pin), .acq_start_pin_out(pin_out), .acq_start_pin_oe(pin_oe),
    .sw_start(sw_start), .acq_stop(acq_stop), .acq_running(acq_running), .acq_start_pulse(pulse),
    .sync_mode_cfg(mode_cfg), .sync_cont_cfg(cont_cfg), .sync_dir_out(dir_cfg), .sync_in(3'h0),
    .sync_clock_outputs(sync_clock_outputs), .sync_oe(sync_oe), .cont_rejected(cont_rejected),
    .camera_selected(camera_selected), .frame_clk(frame_clk), .bus_dev_selected(bus_dev_selected),
    .bus_sync(bus_sync), .storing(storing), .osc_tick(osc_tick), .fixed_half(16'h0002), .sample_clk(sample_clk),
    .fast_clk(fast_clk), .exp_acq_mode(exp_acq_mode), .exp_src_sel(exp_src_sel), .exp_high(32'h00020003),
    .exp_low(32'h00030001), .exp_out(exp_out), .is_master(is_master), .ext_sync_in(ext_sync_in),
    .ext_sync_valid(ext_sync_valid), .local_master_indicator(lmi), .remote_master_indicator(rmi),
    .ext_sync_used(ext_sync_used));
  always #10 mclk = !mclk;
  // Hang guard; the whole sequence needs well under this many cycles
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      bad_count = bad_count + 1;
      close_out;
    end
  end
  // ============================================================
  // Helpers
  function integer fires(input integer sel, input rise);
    fires = (sel == 2) ? 1 : (sel == 1) ? !rise : rise;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // One-cycle strobe: 0 start, 1 stop, 2 load modes
  task strobe(input integer w);
  begin
    @(negedge mclk);
    sw_start = (w == 0);
    acq_stop = (w == 1);
    mode_apply = (w == 2);
    @(negedge mclk);
    {sw_start, acq_stop, mode_apply} = 3'h0;
  end
  endtask
  // Counts level changes of one watched output over n cycles
  task count(input integer b, input integer n);
    reg p;
  begin
    tg = 0;
    p = watch[b];
    repeat (n)
    begin
      @(negedge mclk);
      if (watch[b] !== p)
        tg = tg + 1;
      p = watch[b];
    end
  end
  endtask
  task fin(input [63:0] s);
    $display("Test %0s finished, mismatches %0d", s, bad_count);
  endtask
  task close_out;
  begin
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // ============================================================
  // Main sequence
  initial
  begin
    k = $urandom(82607);
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    count(0, 200);
    chk(tg > 0, 1);
    count(1, 200);
    chk(tg > 0, 1);
    count(2, 200);
    chk(tg, 0);
    {camera_selected, bus_dev_selected} = 2'h0;
    count(0, 4);
    count(0, 100);
    chk(tg, 0);
    count(1, 100);
    chk(tg, 0);
    fin("defaults");
    for (i = 0; i < 8; i = i + 1)
    begin
      trig_edge_sel = (i < 4) ? i : $urandom;
      pin = !pin;
      count(5, 10);
      chk(tg, 2 * fires(trig_edge_sel, pin));
      strobe(1);
    end
    trig_dir_out = 1'b1;
    pin = !pin;
    count(5, 10);
    chk(tg, 0);
    chk(pin_oe, 1);
    strobe(0);
    count(6, 8);
    chk(tg, 2);
    strobe(1);
    trig_dir_out = 1'b0;
    dir_cfg = $urandom;
    count(0, 4);
    chk(sync_oe, dir_cfg);
    dir_cfg = 3'h7;
    fin("trigger");
    for (i = 0; i < 3; i = i + 1)
    begin
      j = $urandom % 3;
      mode_cfg = 9'h004 << (3 * j);
      cont_cfg = 3'h0;
      strobe(2);
      count(j, 4);
      count(j, 100);
      chk(tg, 0);
      strobe(0);
      count(j, 100);
      chk(tg > 4, 1);
      strobe(1);
      count(j, 4);
      count(j, 100);
      chk(tg, 0);
      cont_cfg = 3'h1 << j;
      strobe(2);
      count(j, 100);
      chk(tg > 4, 1);
      mode_cfg = 9'h005 << (3 * j);
      cont_cfg = 3'h0;
      strobe(2);
      strobe(0);
      count(j, 100);
      chk(tg > 4, 1);
      strobe(1);
      mode_cfg = 9'h003 << (3 * j);
      strobe(2);
      count(j, 4);
      a = sync_clock_outputs[j];
      storing = 1'b1;
      count(j, 4);
      chk(sync_clock_outputs[j] != a, 1);
      storing = 1'b0;
    end
    mode_cfg = 9'h100;
    cont_cfg = 3'h4;
    strobe(2);
    count(0, 40);
    strobe(0);
    for (k = 0; k < 40 && pulse !== 1'b1; k = k + 1)
      @(negedge mclk);
    chk(sync_clock_outputs[2], 1);
    chk(pulse, 1);
    strobe(1);
    mode_cfg = 9'h005;
    cont_cfg = 3'h1;
    strobe(2);
    count(0, 4);
    chk(cont_rejected, 0);
    fin("modes");
    exp_src_sel = $urandom;
    count(3, 100);
    chk(tg, 0);
    exp_acq_mode = 1'b1;
    count(3, 200);
    chk(tg > 4, 1);
    count(4, 200);
    chk(tg > 4, 1);
    exp_acq_mode = 1'b0;
    is_master = 1'b1;
    ext_sync_valid = 1'b1;
    count(7, 10);
    count(7, 100);
    chk({lmi, rmi, tg == 0}, 3'h5);
    is_master = 1'b0;
    count(7, 100);
    chk({rmi, tg > 0}, 2'h3);
    fin("bus");
    board_id = 4'h1;
    rst = 1'b1;
    {camera_selected, bus_dev_selected} = 2'h3;
    count(0, 16);
    rst = 1'b0;
    count(0, 100);
    chk({tg == 0, sync_clock_outputs}, 4'h8);
    strobe(2);
    count(0, 4);
    chk(cont_rejected, 1);
    fin("slave");
    close_out;
  end
endmodule // clock_trigger_io_test
